// ---- hw/bcrs_defs.svh ----
`ifndef BCRS_DEFS_SVH
`define BCRS_DEFS_SVH

// command codes of the configuration bytes
`define BCRS_CMD_DELAY 8'hD1
`define BCRS_CMD_MODE 8'hD2
`define BCRS_CMD_FREQ 8'hD3
`define BCRS_CMD_TRIM 8'hD4
`define BCRS_CMD_MARGIN 8'hD5

// field positions
`define BCRS_PGD_MSB 5
`define BCRS_PGD_LSB 3
`define BCRS_POD_MSB 2
`define BCRS_POD_LSB 0
`define BCRS_SST_MSB 3
`define BCRS_SST_LSB 2
`define BCRS_UVL_BIT 1
`define BCRS_CM_BIT 0
`define BCRS_MH_MSB 7
`define BCRS_MH_LSB 4
`define BCRS_ML_MSB 3
`define BCRS_ML_LSB 0

// reset values (unprogrammed defaults), implemented bits only
`define BCRS_DELAY_RST 6'h12
`define BCRS_MODE_RST 4'h0
`define BCRS_FREQ_RST 3'h2
`define BCRS_TRIM_RST 5'h10
`define BCRS_MARGIN_RST 8'h55

// timing: clock rate and times in microseconds
`define BCRS_MCLK_MHZ 40
`define BCRS_TICK_US 1
`define BCRS_US_CYCLES (`BCRS_TICK_US * `BCRS_MCLK_MHZ)
`define BCRS_PGD_BASE_US 256
`define BCRS_PGD_MAX_US 131072
`define BCRS_POD_OFFS_US 100
`define BCRS_SS_BASE_US 1000
`define BCRS_HICCUP_BASE_US 8960
`define BCRS_HICCUP_SS_MULT 7
`define BCRS_STEP_BASE_US 4
`define BCRS_LATENCY_US 50

// reference scale: 1 code = 0.01 % of nominal
`define BCRS_REF_NOMINAL 10000
`define BCRS_TRIM_STEP_BP 75
`define BCRS_TRIM_MAX_BP 900

`endif

// ---- hw/bcrs_pkg.sv ----
package bcrs_pkg;
    // margin selection as set by the operation command
    typedef enum logic [1:0] {
        MRG_NONE = 2'b00,
        MRG_LOW = 2'b01,
        MRG_HIGH = 2'b10
    } bcrs_margin_t;
    // power sequencer states, one-hot
    typedef enum logic [6:0] {
        SQ_OFF = 7'b000_0001,
        SQ_POD = 7'b000_0010,
        SQ_SS = 7'b000_0100,
        SQ_PGD = 7'b000_1000,
        SQ_ON = 7'b001_0000,
        SQ_HICCUP = 7'b010_0000,
        SQ_LATCHED = 7'b100_0000
    } bcrs_seq_t;
endpackage

// ---- hw/bcrs_top.sv ----
`timescale 1ns/10ps
`include "bcrs_defs.svh"

// Overview of operation
// - power-good delay from bits 5:3, doubling codes except top code 131072us
// - power-on delay from bits 2:0, 356us up
// - soft-start 1/2/4/8 ms from mode bits 3:2
// - undervoltage: hiccup 8.96ms+7 soft-starts, or latch
// - discontinuous in soft-start, forced continuous afterwards
// - switching frequency select from bits 2:0
// - fine trim 0.75% steps, saturating at 9%
// - trim and margin combine by multiplication
// - reference walks one step at a time
// - trim step every 4/8/16/32 us per field
// - margin changes use same step timing
// - margin-high level from bits 7:4
// - margin-low level from bits 3:0
// - operation command picks high or low margin
// - trim write waits 50 us before stepping
// - margin-high command waits same latency
// - margin rewrite while margining retargets after the same latency
// - unimplemented upper bits ignored on write
module bcrs_top #(
    parameter int US_DIV = `BCRS_US_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // command port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regCmd,
    input wire logic [7:0] regWrData,
    input wire logic opWrite,
    input wire bcrs_pkg::bcrs_margin_t opMargin,
    output logic [7:0] rdData_q,
    output logic rdValid_q,
    // converter control
    input wire logic enableReq,
    input wire logic uvFault,
    output logic [2:0] freqSel_q,
    output logic powerStageOn_q,
    output logic fccMode_q,
    output logic powerGood_q,
    output logic latchedOff_q,
    output logic [15:0] refCode_q,
    output logic slewBusy_q
);
    import bcrs_pkg::*;

    // configuration state
    logic [5:0] cfgDelay_q, cfgDelay_d;
    logic [3:0] cfgMode_q, cfgMode_d;
    logic [2:0] freqSel_d;
    logic [4:0] cfgTrim_q, cfgTrim_d;
    logic [7:0] cfgMargin_q, cfgMargin_d;
    bcrs_margin_t marginSel_q, marginSel_d;
    logic [7:0] rdData_d;
    logic rdValid_d;
    logic wrDelay, wrMode, wrFreq, wrTrim, wrMargin;

    // register writes, reads and operation command
    always_comb
    begin
        wrDelay = regWrite && regCmd == `BCRS_CMD_DELAY;
        wrMode = regWrite && regCmd == `BCRS_CMD_MODE;
        wrFreq = regWrite && regCmd == `BCRS_CMD_FREQ;
        wrTrim = regWrite && regCmd == `BCRS_CMD_TRIM;
        wrMargin = regWrite && regCmd == `BCRS_CMD_MARGIN;
        // upper bits are simply not stored
        cfgDelay_d = wrDelay ? regWrData[5:0] : cfgDelay_q;
        cfgMode_d = wrMode ? regWrData[3:0] : cfgMode_q;
        freqSel_d = wrFreq ? regWrData[2:0] : freqSel_q;
        cfgTrim_d = wrTrim ? regWrData[4:0] : cfgTrim_q;
        cfgMargin_d = wrMargin ? regWrData : cfgMargin_q;
        marginSel_d = opWrite ? opMargin : marginSel_q;
        rdValid_d = regRead;
        // readback, unknown codes answer zero
        case (regCmd)
            `BCRS_CMD_DELAY: rdData_d = {2'b00, cfgDelay_q};
            `BCRS_CMD_MODE: rdData_d = {4'h0, cfgMode_q};
            `BCRS_CMD_FREQ: rdData_d = {5'h00, freqSel_q};
            `BCRS_CMD_TRIM: rdData_d = {3'h0, cfgTrim_q};
            `BCRS_CMD_MARGIN: rdData_d = cfgMargin_q;
            default: rdData_d = 8'h00;
        endcase
        if (!regRead)
            rdData_d = rdData_q;
    end

    // reset loads the unprogrammed defaults
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgDelay_q <= `BCRS_DELAY_RST;
            cfgMode_q <= `BCRS_MODE_RST;
            freqSel_q <= `BCRS_FREQ_RST;
            cfgTrim_q <= `BCRS_TRIM_RST;
            cfgMargin_q <= `BCRS_MARGIN_RST;
            marginSel_q <= MRG_NONE;
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
        end
        else
        begin
            cfgDelay_q <= cfgDelay_d;
            cfgMode_q <= cfgMode_d;
            freqSel_q <= freqSel_d;
            cfgTrim_q <= cfgTrim_d;
            cfgMargin_q <= cfgMargin_d;
            marginSel_q <= marginSel_d;
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    // microsecond time base and derived durations
    logic [5:0] usCnt_q, usCnt_d;
    logic usTick;
    logic [17:0] pgdUs, podUs, ssUs, hicUs;
    logic [5:0] stepUs;

    always_comb
    begin
        usTick = usCnt_q == 6'(US_DIV - 1);
        usCnt_d = usTick ? 6'h00 : usCnt_q + 6'h01;
        // codes double per step; top power-good code is special
        pgdUs = 18'(`BCRS_PGD_BASE_US) << cfgDelay_q[5:3];
        if (cfgDelay_q[5:3] == 3'h7)
            pgdUs = 18'(`BCRS_PGD_MAX_US);
        podUs = (18'(`BCRS_PGD_BASE_US) << cfgDelay_q[2:0])
            + 18'(`BCRS_POD_OFFS_US);
        ssUs = 18'(`BCRS_SS_BASE_US) << cfgMode_q[3:2];
        hicUs = 18'(`BCRS_HICCUP_BASE_US)
            + 18'(`BCRS_HICCUP_SS_MULT) * ssUs;
        stepUs = 6'(`BCRS_STEP_BASE_US) << cfgMode_q[3:2];
    end

    // power sequencer
    bcrs_seq_t seq_q, seq_d;
    logic [17:0] tmr_q, tmr_d;
    logic tmrDone;

    always_comb
    begin
        seq_d = seq_q;
        tmr_d = tmr_q;
        tmrDone = usTick && tmr_q == 18'h0_0000;
        if (usTick && tmr_q != 18'h0_0000)
            tmr_d = tmr_q - 18'h0_0001;
        case (seq_q)
            SQ_OFF:
                if (enableReq)
                begin
                    seq_d = SQ_POD;
                    tmr_d = podUs;
                end
            SQ_POD:
                if (tmrDone)
                begin
                    seq_d = SQ_SS;
                    tmr_d = ssUs;
                end
            SQ_SS:
                if (tmrDone)
                begin
                    seq_d = SQ_PGD;
                    tmr_d = pgdUs;
                end
            SQ_PGD:
                if (tmrDone)
                    seq_d = SQ_ON;
            SQ_ON:
                if (uvFault)
                begin
                    // latch bit picks hard stop or retry
                    seq_d = cfgMode_q[1] ? SQ_LATCHED : SQ_HICCUP;
                    tmr_d = hicUs;
                end
            SQ_HICCUP:
                if (tmrDone)
                begin
                    seq_d = SQ_SS;
                    tmr_d = ssUs;
                end
            SQ_LATCHED:
                seq_d = SQ_LATCHED;
            default:
                seq_d = SQ_OFF;
        endcase
        // dropping enable always shuts down and clears latch-off
        if (!enableReq)
            seq_d = SQ_OFF;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_q <= SQ_OFF;
            tmr_q <= 18'h0_0000;
            usCnt_q <= 6'h00;
            powerStageOn_q <= 1'b0;
            fccMode_q <= 1'b0;
            powerGood_q <= 1'b0;
            latchedOff_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            tmr_q <= tmr_d;
            usCnt_q <= usCnt_d;
            powerStageOn_q <= seq_d inside {SQ_SS, SQ_PGD, SQ_ON};
            // forced continuous only once soft-start is over
            fccMode_q <= cfgMode_q[0]
                && seq_d inside {SQ_PGD, SQ_ON};
            powerGood_q <= seq_d == SQ_ON;
            latchedOff_q <= seq_d == SQ_LATCHED;
        end
    end

    // level tables, in 0.01 % units
    function automatic logic [15:0] trimBp(input logic [4:0] c);
        logic [15:0] mag;
        mag = 16'h0000;
        if (c >= 5'h1C || c <= 5'h03)
            mag = 16'(`BCRS_TRIM_MAX_BP);
        else if (c[4])
            mag = 16'(`BCRS_TRIM_STEP_BP) * {12'h000, c[3:0]};
        else
            mag = 16'(`BCRS_TRIM_STEP_BP) * {12'h000, ~c[3:0]};
        return mag;
    endfunction

    function automatic logic [15:0] highBp(input logic [3:0] c);
        case (c)
            4'h0, 4'h1: return 16'd90;
            4'h2: return 16'd180;
            4'h3: return 16'd280;
            4'h4: return 16'd370;
            4'h5: return 16'd470;
            4'h6: return 16'd570;
            4'h7: return 16'd670;
            4'h8: return 16'd770;
            4'h9: return 16'd880;
            4'hA: return 16'd990;
            4'hB: return 16'd1090;
            default: return 16'd1200;
        endcase
    endfunction

    function automatic logic [15:0] lowBp(input logic [3:0] c);
        case (c)
            4'h0: return 16'd0;
            4'h1: return 16'd110;
            4'h2: return 16'd210;
            4'h3: return 16'd320;
            4'h4: return 16'd420;
            4'h5: return 16'd520;
            4'h6: return 16'd620;
            4'h7: return 16'd710;
            4'h8: return 16'd810;
            4'h9, 4'hA: return 16'd900;
            4'hB: return 16'd1070;
            default: return 16'd1160;
        endcase
    endfunction

    // reference slew: latency, then one code per step interval
    logic [5:0] stepCnt_q, stepCnt_d;
    logic [5:0] latCnt_q, latCnt_d;
    logic latPend_q, latPend_d;
    logic [15:0] slewTarget_q, slewTarget_d, refCode_d;
    logic [15:0] trimF, margF;
    logic [31:0] prod;
    logic [15:0] tgtNow;
    logic stepFire, arm;

    always_comb
    begin
        trimF = cfgTrim_q[4] ? 16'(`BCRS_REF_NOMINAL) + trimBp(cfgTrim_q)
            : 16'(`BCRS_REF_NOMINAL) - trimBp(cfgTrim_q);
        case (marginSel_q)
            MRG_HIGH: margF = 16'(`BCRS_REF_NOMINAL)
                + highBp(cfgMargin_q[7:4]);
            MRG_LOW: margF = 16'(`BCRS_REF_NOMINAL)
                - lowBp(cfgMargin_q[3:0]);
            default: margF = 16'(`BCRS_REF_NOMINAL);
        endcase
        prod = {16'h0000, trimF} * {16'h0000, margF};
        tgtNow = 16'(prod / 32'(`BCRS_REF_NOMINAL));
        // trim write, operation command or margin rewrite in use
        arm = wrTrim || opWrite
            || (wrMargin && marginSel_q != MRG_NONE);
        latCnt_d = latCnt_q;
        latPend_d = latPend_q;
        slewTarget_d = slewTarget_q;
        if (arm)
        begin
            latPend_d = 1'b1;
            latCnt_d = 6'(`BCRS_LATENCY_US);
        end
        else if (latPend_q && usTick)
        begin
            if (latCnt_q == 6'h00)
            begin
                latPend_d = 1'b0;
                slewTarget_d = tgtNow;
            end
            else
                latCnt_d = latCnt_q - 6'h01;
        end
        stepFire = usTick && stepCnt_q == stepUs - 6'h01;
        stepCnt_d = stepCnt_q;
        if (usTick)
            stepCnt_d = stepFire ? 6'h00 : stepCnt_q + 6'h01;
        refCode_d = refCode_q;
        // never jump: single code per step toward target
        if (stepFire && refCode_q < slewTarget_q)
            refCode_d = refCode_q + 16'h0001;
        else if (stepFire && refCode_q > slewTarget_q)
            refCode_d = refCode_q - 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stepCnt_q <= 6'h00;
            latCnt_q <= 6'h00;
            latPend_q <= 1'b0;
            slewTarget_q <= 16'(`BCRS_REF_NOMINAL);
            refCode_q <= 16'(`BCRS_REF_NOMINAL);
            slewBusy_q <= 1'b0;
        end
        else
        begin
            stepCnt_q <= stepCnt_d;
            latCnt_q <= latCnt_d;
            latPend_q <= latPend_d;
            slewTarget_q <= slewTarget_d;
            refCode_q <= refCode_d;
            slewBusy_q <= latPend_d || refCode_d != slewTarget_d;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_ref_one_step: assert property (
        $changed(refCode_q) |-> (refCode_q - $past(refCode_q) == 16'h0001
            || $past(refCode_q) - refCode_q == 16'h0001))
        else $error("reference moved by more than one code");
    chk_ref_on_tick: assert property (
        $changed(refCode_q) |-> $past(stepFire))
        else $error("reference moved outside a step slot");
    chk_trim_latency: assert property (
        wrTrim |=> $stable(slewTarget_q) [*8])
        else $error("target moved before command latency");
    chk_fcc_soft_start: assert property (
        seq_q == SQ_SS |-> !fccMode_q)
        else $error("forced continuous during soft-start");
    chk_uv_latch: assert property (
        seq_q == SQ_ON && uvFault && enableReq && cfgMode_q[1]
            |=> seq_q == SQ_LATCHED && latchedOff_q)
        else $error("latch-off not taken");
    chk_uv_hiccup: assert property (
        seq_q == SQ_ON && uvFault && enableReq && !cfgMode_q[1]
            |=> seq_q == SQ_HICCUP && tmr_q == hicUs)
        else $error("hiccup not taken");
    chk_pg_state: assert property (
        powerGood_q |-> $past(seq_q == SQ_ON || seq_d == SQ_ON))
        else $error("power good outside on state");
    chk_margin_high: assert property (
        opWrite && opMargin == MRG_HIGH |=> marginSel_q == MRG_HIGH)
        else $error("margin high not selected");
    chk_read_mask: assert property (
        regRead && regCmd == `BCRS_CMD_TRIM
            |=> rdValid_q && rdData_q[7:5] == 3'h0)
        else $error("unimplemented trim bits read back");
    cov_power_good: cover property ($rose(powerGood_q));
    cov_hiccup: cover property (seq_q == SQ_HICCUP ##1 seq_q == SQ_SS);
    cov_slew_done: cover property ($fell(slewBusy_q));
endmodule

// ---- test/bcrs_host_model.sv ----
`timescale 1ns/10ps
// host end of the command link: byte writes, byte reads, operation
module bcrs_host_model (
    // clock
    input wire logic mclk,
    // requests toward the device
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regCmd,
    output logic [7:0] regWrData,
    output logic opWrite,
    output bcrs_pkg::bcrs_margin_t opMargin,
    // answer from the device
    input wire logic [7:0] rdData_q,
    input wire logic rdValid_q
);
    import bcrs_pkg::*;

    // idle at time zero, no request pending
    initial
    begin
        regWrite = 1'b0;
        regRead = 1'b0;
        opWrite = 1'b0;
        regCmd = 8'h00;
        regWrData = 8'h00;
        opMargin = MRG_NONE;
    end

    // one byte write, strobe held across a single rising edge
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        @(negedge mclk);
        regCmd = cmd;
        regWrData = data;
        regWrite = 1'b1;
        @(negedge mclk);
        regWrite = 1'b0;
        // released data: show the inverse so stale bytes are not trusted
        regWrData = ~data;
    endtask

    // one byte read, answer taken one cycle after the strobe
    task automatic rd(input logic [7:0] cmd, output logic [7:0] data,
                      output logic valid);
        @(negedge mclk);
        regCmd = cmd;
        regRead = 1'b1;
        @(negedge mclk);
        regRead = 1'b0;
        data = rdData_q;
        valid = rdValid_q;
    endtask

    // operation command enables or drops margining
    task automatic op(input bcrs_margin_t m);
        @(negedge mclk);
        opMargin = m;
        opWrite = 1'b1;
        @(negedge mclk);
        opWrite = 1'b0;
        // released select toggles so a late sample shows up
        opMargin = bcrs_margin_t'(~m);
    endtask
endmodule

// ---- test/buck_config_and_reference_slew_test.sv ----
`timescale 1ns/10ps
module buck_config_and_reference_slew_test;
    import bcrs_pkg::*;
    // one tick per cycle keeps millisecond phases short
    localparam int US_DIV = 1;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic enableReq = 1'b0;
    logic uvFault = 1'b0;
    logic regWrite, regRead, opWrite, rdValid_q;
    logic [7:0] regCmd, regWrData, rdData_q;
    bcrs_margin_t opMargin;
    logic [2:0] freqSel_q;
    logic powerStageOn_q, fccMode_q, powerGood_q, latchedOff_q, slewBusy_q;
    logic [15:0] refCode_q;
    logic [15:0] refPrev = 16'h2710;
    int err_total = 0;
    int cmp_count = 0;

    always #12.5 mclk = ~mclk;

    bcrs_top #(.US_DIV(US_DIV)) dut (.mclk(mclk), .rst_n(rst_n),
        .regWrite(regWrite), .regRead(regRead), .regCmd(regCmd),
        .regWrData(regWrData), .opWrite(opWrite), .opMargin(opMargin),
        .rdData_q(rdData_q), .rdValid_q(rdValid_q),
        .enableReq(enableReq), .uvFault(uvFault), .freqSel_q(freqSel_q),
        .powerStageOn_q(powerStageOn_q), .fccMode_q(fccMode_q),
        .powerGood_q(powerGood_q), .latchedOff_q(latchedOff_q),
        .refCode_q(refCode_q), .slewBusy_q(slewBusy_q));

    bcrs_host_model host (.mclk(mclk), .regWrite(regWrite),
        .regRead(regRead), .regCmd(regCmd), .regWrData(regWrData),
        .opWrite(opWrite), .opMargin(opMargin), .rdData_q(rdData_q),
        .rdValid_q(rdValid_q));

    // compare a byte
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a reference code
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a cycle count against a window
    task automatic chk_rng(input int n, input int lo, input int hi);
        cmp_count++;
        if (n < lo || n > hi)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
        end
    endtask

    // sequencer output chosen by index
    function automatic logic pick(input int s);
        case (s)
            0: pick = powerStageOn_q;
            1: pick = fccMode_q;
            2: pick = powerGood_q;
            default: pick = latchedOff_q;
        endcase
    endfunction

    // count cycles until an output reaches a level, bounded
    task automatic wait_for(input int s, input logic lvl, input int lo,
                            input int hi);
        int n;
        n = 0;
        while (pick(s) !== lvl && n <= hi)
        begin
            @(negedge mclk);
            n++;
        end
        chk_rng(n, lo, hi);
    endtask

    // wait for the slew to finish, then check where it stopped
    task automatic settle(input logic [15:0] exp);
        int n;
        n = 0;
        repeat (2) @(negedge mclk);
        // still inside the command latency, so busy must show
        chk8({7'h00, slewBusy_q}, 8'h01);
        while (slewBusy_q !== 1'b0 && n < 9000)
        begin
            @(negedge mclk);
            n++;
        end
        chk8({7'h00, slewBusy_q}, 8'h00);
        chk16(refCode_q, exp);
    endtask

    // every reference move is a single code
    always @(negedge mclk)
    begin
        if (rst_n && refCode_q !== refPrev)
        begin
            chk16((refCode_q > refPrev) ? refCode_q - refPrev
                                        : refPrev - refCode_q, 16'h0001);
            refPrev = refCode_q;
        end
    end

    // power-up defaults read back, unmapped code reads zero
    task automatic t_defaults;
        logic [7:0] d;
        logic v;
        logic [7:0] cmd [6];
        logic [7:0] exp [6];
        cmd = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5};
        exp = '{8'h00, 8'h12, 8'h00, 8'h02, 8'h10, 8'h55};
        for (int i = 0; i < 6; i++)
        begin
            host.rd(cmd[i], d, v);
            chk8({7'h00, v}, 8'h01);
            chk8(d, exp[i]);
        end
        chk8({5'h00, freqSel_q}, 8'h02);
    endtask

    // unimplemented bits dropped, every frequency code reaches the pins
    task automatic t_upper;
        logic [7:0] d;
        logic v;
        logic [7:0] exp [4];
        exp = '{8'h3F, 8'h0F, 8'h07, 8'h1F};
        for (int i = 0; i < 4; i++)
        begin
            host.wr(8'hD1 + 8'(i), 8'hFF);
            host.rd(8'hD1 + 8'(i), d, v);
            chk8(d, exp[i]);
        end
        host.wr(8'hD4, 8'h10);
        host.wr(8'hD1, 8'h12);
        host.wr(8'hD2, 8'h00);
        for (int i = 7; i >= 0; i--)
        begin
            host.wr(8'hD3, 8'(i));
            repeat (2) @(negedge mclk);
            chk8({5'h00, freqSel_q}, 8'(i));
        end
    endtask

    // trim latency, step spacing, saturation
    task automatic t_trim;
        int n;
        logic [15:0] r;
        host.wr(8'hD2, 8'h04);
        host.wr(8'hD4, 8'h11);
        n = 0;
        while (refCode_q === 16'h2710 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        chk_rng(n, 50, 62);
        r = refCode_q;
        n = 0;
        while (refCode_q === r && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chk_rng(n, 8 * US_DIV, 8 * US_DIV);
        settle(16'h275B);
        host.wr(8'hD2, 8'h00);
        host.wr(8'hD4, 8'h1E);
        settle(16'h2A94);
        // slowest step code, walking downward by one code
        host.wr(8'hD2, 8'h0C);
        host.wr(8'hD4, 8'h1B);
        n = 0;
        while (refCode_q === 16'h2A94 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        r = refCode_q;
        chk16(r, 16'h2A93);
        n = 0;
        while (refCode_q === r && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chk_rng(n, 32 * US_DIV, 32 * US_DIV);
        host.wr(8'hD2, 8'h00);
        host.wr(8'hD4, 8'h1E);
        settle(16'h2A94);
    endtask

    // margins multiply with trim, rewrite retargets, unprinted code
    task automatic t_margin;
        host.op(MRG_HIGH);
        settle(16'h2C94);
        host.wr(8'hD5, 8'hC5);
        settle(16'h2FB0);
        host.op(MRG_LOW);
        settle(16'h285D);
        host.wr(8'hD5, 8'hCA);
        settle(16'h26BF);
        host.op(MRG_NONE);
        settle(16'h2A94);
    endtask

    // start-up phases, hiccup retry, latch-off
    task automatic t_seq;
        host.wr(8'hD2, 8'h01);
        @(negedge mclk);
        enableReq = 1'b1;
        wait_for(0, 1'b1, 1120, 1130);
        chk8({7'h00, fccMode_q}, 8'h00);
        wait_for(1, 1'b1, 995, 1008);
        wait_for(2, 1'b1, 1018, 1032);
        @(negedge mclk);
        uvFault = 1'b1;
        @(negedge mclk);
        uvFault = 1'b0;
        wait_for(0, 1'b0, 0, 4);
        wait_for(0, 1'b1, 15945, 15972);
        wait_for(2, 1'b1, 2010, 2040);
        host.wr(8'hD2, 8'h03);
        uvFault = 1'b1;
        @(negedge mclk);
        uvFault = 1'b0;
        wait_for(3, 1'b1, 0, 4);
        chk8({7'h00, powerStageOn_q}, 8'h00);
        enableReq = 1'b0;
        wait_for(3, 1'b0, 0, 4);
    endtask

    // verdict and end of run
    task automatic report_and_stop;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        t_defaults();
        t_upper();
        t_trim();
        t_margin();
        t_seq();
        report_and_stop();
    end

    // watchdog, about twice the expected run
    initial
    begin
        repeat (80000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule
